// file: rtl/iec_pkg.sv
package iec_pkg;

  // Register map, byte addresses on the AXI4-Lite bus
  localparam logic [3:0]  CTRL_ADDR    = 4'h0;  // interrupt_control_two
  localparam logic [3:0]  IRQ_ADDR     = 4'h4;  // Detected edges, write one to clear
  localparam int          NUM_EXT      = 5;
  localparam int          ALT_BIT      = 15;
  localparam int          STAT_BIT     = 14;
  localparam logic [15:0] CTRL_WMASK   = 16'h801F;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Write side of the register bus
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } iec_wreq_t;

  // Bus state machine, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRESP = 3'b010,
    ST_RRESP = 3'b100
  } iec_state_t;

endpackage

// file: rtl/iec_ctrl.sv
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Function
// R1: bit 15 selects alternate vector table
// R2: read-only status shows disable instruction active
// R3: per-input polarity: 1 falling, 0 rising
// R4: bits 13 to 5 read zero, ignore writes
// R5: implemented bits reset to zero
module iec_ctrl #(
  parameter int NUM_EXT = iec_pkg::NUM_EXT
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               disable_instr_active,
  input  wire logic [NUM_EXT-1:0] ext_irq,
  output logic                    alternate_vector_table_select,
  output logic [NUM_EXT-1:0]      ext_irq_event
);

  // Register layout reserves exactly this many polarity bits
  if (NUM_EXT != iec_pkg::NUM_EXT) begin : g_bad_num_ext
    $error("NUM_EXT must match register layout");
  end

  iec_pkg::iec_state_t state_reg, state_next;
  logic                aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  iec_pkg::iec_wreq_t  wreq_reg, wreq_next;
  logic [15:0]         ctrl_reg, ctrl_next;
  logic                stat_reg, stat_next;
  logic                awready_reg, awready_next, wready_reg, wready_next;
  logic                arready_reg, arready_next;
  logic [NUM_EXT-1:0]  pin_reg, pin_next;
  logic [NUM_EXT-1:0]  pend_reg, pend_next;
  logic [NUM_EXT-1:0]  evt_reg, evt_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic [1:0]          bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic                bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [NUM_EXT-1:0]  edge_det;

  // Byte-lane merge of write data into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) v[7:0]  = d[7:0];
    if (s[1]) v[15:8] = d[15:8];
    return (v & m) | (old & ~m);
  endfunction

  // Edge detection per input, polarity from the low control bits
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      edge_det[i] = ctrl_reg[i] ? (pin_reg[i] & ~ext_irq[i])   // R3
                                : (~pin_reg[i] & ext_irq[i]);  // R3
    end
  end

  // Bus slave, control register and edge capture
  always_comb begin
    logic [15:0] rd16;
    rd16        = 16'h0000;
    state_next  = state_reg;
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    wreq_next   = wreq_reg;
    ctrl_next   = ctrl_reg;
    stat_next   = disable_instr_active;
    pin_next    = ext_irq;
    evt_next    = edge_det;
    pend_next   = pend_reg;
    rdata_next  = rdata_reg;
    bresp_next  = bresp_reg;
    rresp_next  = rresp_reg;
    bvalid_next = bvalid_reg;
    rvalid_next = rvalid_reg;
    unique case (state_reg)
      iec_pkg::ST_IDLE: begin
        if (s_axi_awvalid && !aw_got_reg) begin
          aw_got_next        = 1'b1;
          wreq_next.addr     = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_reg) begin
          w_got_next         = 1'b1;
          wreq_next.data     = s_axi_wdata;
          wreq_next.strb     = s_axi_wstrb;
        end
        if (aw_got_reg && w_got_reg) begin
          aw_got_next = 1'b0;
          w_got_next  = 1'b0;
          bvalid_next = 1'b1;
          bresp_next  = iec_pkg::RESP_OKAY;
          // Only the writable mask reaches storage; status bit and 13:5 stay out
          if (wreq_reg.addr == iec_pkg::CTRL_ADDR)
            ctrl_next = merge16(ctrl_reg, wreq_reg.data, wreq_reg.strb,
                                iec_pkg::CTRL_WMASK);  // R2 R4
          else if (wreq_reg.addr == iec_pkg::IRQ_ADDR)
            pend_next = pend_reg & ~(wreq_reg.data[NUM_EXT-1:0] & {NUM_EXT{wreq_reg.strb[0]}});
          else
            bresp_next = iec_pkg::RESP_SLVERR;
          state_next = iec_pkg::ST_WRESP;
        end else if (s_axi_arvalid) begin
          rvalid_next = 1'b1;
          rresp_next  = iec_pkg::RESP_OKAY;
          if (s_axi_araddr == iec_pkg::CTRL_ADDR) begin
            rd16           = ctrl_reg & iec_pkg::CTRL_WMASK;  // R4
            rd16[iec_pkg::STAT_BIT] = stat_reg;               // R2
          end else if (s_axi_araddr == iec_pkg::IRQ_ADDR) begin
            rd16[NUM_EXT-1:0] = pend_reg;
          end else begin
            rresp_next = iec_pkg::RESP_SLVERR;
          end
          rdata_next = {16'h0000, rd16};
          state_next = iec_pkg::ST_RRESP;
        end
      end
      iec_pkg::ST_WRESP: begin
        if (s_axi_bready) begin
          bvalid_next = 1'b0;
          state_next  = iec_pkg::ST_IDLE;
        end
      end
      iec_pkg::ST_RRESP: begin
        if (s_axi_rready) begin
          rvalid_next = 1'b0;
          state_next  = iec_pkg::ST_IDLE;
        end
      end
      default: state_next = iec_pkg::ST_IDLE;
    endcase
    // New edges win over a clear in the same cycle
    pend_next = pend_next | edge_det;
    // Readies come from the next state so they leave a flop with unchanged timing
    awready_next = (state_next == iec_pkg::ST_IDLE) && !aw_got_next;
    wready_next  = (state_next == iec_pkg::ST_IDLE) && !w_got_next;
    arready_next = (state_next == iec_pkg::ST_IDLE) && !(aw_got_next && w_got_next);
  end

  // Registers, all set by reset: ready flags to one, state_reg to ST_IDLE, the rest to zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg  <= iec_pkg::ST_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      wreq_reg   <= '0;
      ctrl_reg   <= iec_pkg::CTRL_RESET;  // R5
      stat_reg   <= 1'b0;                 // R5
      pin_reg    <= '0;
      pend_reg   <= '0;
      evt_reg    <= '0;
      rdata_reg  <= 32'h00000000;
      bresp_reg  <= iec_pkg::RESP_OKAY;
      rresp_reg  <= iec_pkg::RESP_OKAY;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      state_reg  <= state_next;
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      wreq_reg   <= wreq_next;
      ctrl_reg   <= ctrl_next;
      stat_reg   <= stat_next;
      pin_reg    <= pin_next;
      pend_reg   <= pend_next;
      evt_reg    <= evt_next;
      rdata_reg  <= rdata_next;
      bresp_reg  <= bresp_next;
      rresp_reg  <= rresp_next;
      bvalid_reg <= bvalid_next;
      rvalid_reg <= rvalid_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
    end
  end

  // Ready flags are registered so every output comes from a flop
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign alternate_vector_table_select = ctrl_reg[iec_pkg::ALT_BIT];  // R1
  assign ext_irq_event = evt_reg;

  a_alt_follows: assert property (@(posedge clk) disable iff (reset)  // R1
    $rose(bvalid_reg) && wreq_reg.addr == iec_pkg::CTRL_ADDR && wreq_reg.strb[1]
    |-> alternate_vector_table_select == wreq_reg.data[iec_pkg::ALT_BIT])
    else $error("vector select not taken from write");
  a_status_ro: assert property (@(posedge clk) disable iff (reset)  // R2
    rvalid_reg && !$past(rvalid_reg) && $past(s_axi_araddr) == iec_pkg::CTRL_ADDR
    |-> rdata_reg[iec_pkg::STAT_BIT] == $past(stat_reg))
    else $error("status bit read wrong");
  a_rise_edge: assert property (@(posedge clk) disable iff (reset)  // R3
    !ctrl_reg[0] && !pin_reg[0] && ext_irq[0] |=> ext_irq_event[0])
    else $error("rising edge missed");
  a_fall_edge: assert property (@(posedge clk) disable iff (reset)  // R3
    ctrl_reg[0] && $fell(ext_irq[0]) |-> ##1 ext_irq_event[0])
    else $error("falling edge missed");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (reset)  // R4
    ctrl_reg[13:5] == 9'h000 && rdata_reg[13:5] == 9'h000)
    else $error("unimplemented bits nonzero");
  a_reset_zero: assert property (@(posedge clk)  // R5
    $fell(reset) |-> ctrl_reg == iec_pkg::CTRL_RESET)
    else $error("control not zero after reset");
  a_bresp_hold: assert property (@(posedge clk) disable iff (reset)
    bvalid_reg && !s_axi_bready |=> bvalid_reg)
    else $error("write response dropped");
  a_rresp_hold: assert property (@(posedge clk) disable iff (reset)
    rvalid_reg && !s_axi_rready |=> rvalid_reg && $stable(rdata_reg))
    else $error("read response dropped");

endmodule

// file: test/iec_pins.sv
`timescale 1ns/10ps
// External interrupt pins; levels change only just after a clock edge
module iec_pins (
  input  wire logic                       clk,
  output logic [iec_pkg::NUM_EXT-1:0]     pins
);
  logic [iec_pkg::NUM_EXT-1:0] level_reg = 5'h00;

  assign pins = level_reg;

  // Sets all pins to the levels in v together, so several edges can land at once
  task automatic drive(input logic [iec_pkg::NUM_EXT-1:0] v);
    @(posedge clk);
    level_reg <= v;
  endtask
endmodule

// file: test/test_irq_control_edge_vector_select.sv
`timescale 1ns/10ps
module test_irq_control_edge_vector_select;
  logic        clk = 1'b0, reset = 1'b1, dis = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, alt;
  logic [1:0]  bresp, rresp, resp;
  logic [4:0]  pins, ev;
  logic [31:0] rd_val;
  int          mismatches = 0, checks = 0;

  // Free-running clock, 10 ns period
  always #5 clk = ~clk;

  iec_ctrl i_iec_ctrl (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .disable_instr_active(dis), .ext_irq(pins), .alternate_vector_table_select(alt),
    .ext_irq_event(ev));
  iec_pins i_iec_pins (.clk(clk), .pins(pins));

  task automatic summarize;
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Ready and valid are flop-driven, so the mid-cycle sample is what the edge sees
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int  n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!tb && n < 20) begin
      @(negedge clk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end
    if (!tb) begin mismatches++; summarize(); end
  endtask

  task automatic rd(input logic [3:0] a);
    int  n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!tr && n < 20) begin
      @(negedge clk);
      ta = arvalid & arready; tr = rvalid; rd_val = rdata; resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
    end
    if (!tr) begin mismatches++; summarize(); end
  endtask

  // Collects event pulses over three cycles after one pin change
  task automatic edge_test(input logic [4:0] pol, input logic [4:0] from, input logic [4:0] to,
                           input logic [4:0] exp);
    logic [4:0] seen;
    wr(iec_pkg::CTRL_ADDR, {27'h0, pol});
    i_iec_pins.drive(from);
    repeat (3) @(posedge clk);
    seen = 5'h00;
    i_iec_pins.drive(to);
    repeat (3) begin
      @(negedge clk);
      seen |= ev;
    end
    check({27'h0, seen}, {27'h0, exp});
  endtask

  task automatic scen_reg;
    rd(iec_pkg::CTRL_ADDR); check(rd_val, 32'h0);
    check({31'h0, alt}, 32'h0);
    wr(iec_pkg::CTRL_ADDR, 32'hFFFF_FFFF); check({30'h0, resp}, {30'h0, iec_pkg::RESP_OKAY});
    rd(iec_pkg::CTRL_ADDR); check(rd_val, 32'h0000_801F);
    @(negedge clk);
    check({31'h0, alt}, 32'h1);
    wr(iec_pkg::CTRL_ADDR, 32'h0000_7FE0);
    @(negedge clk);
    check({31'h0, alt}, 32'h0);
    wr(4'h8, 32'hFFFF_FFFF); check({30'h0, resp}, {30'h0, iec_pkg::RESP_SLVERR});
    rd(iec_pkg::CTRL_ADDR); check(rd_val, 32'h0);
    rd(4'hC); check({30'h0, resp}, {30'h0, iec_pkg::RESP_SLVERR});
  endtask

  // Status bit follows the core; a write must not disturb it
  task automatic scen_disable;
    @(posedge clk) dis <= 1'b1;
    repeat (2) @(posedge clk);
    rd(iec_pkg::CTRL_ADDR); check(rd_val, 32'h0000_4000);
    wr(iec_pkg::CTRL_ADDR, 32'h0);
    rd(iec_pkg::CTRL_ADDR); check(rd_val, 32'h0000_4000);
    @(posedge clk) dis <= 1'b0;
    repeat (2) @(posedge clk);
    wr(iec_pkg::CTRL_ADDR, 32'h0000_4000);
    rd(iec_pkg::CTRL_ADDR); check(rd_val, 32'h0);
  endtask

  // Captured edges stay until software writes ones to clear them
  task automatic scen_pending;
    rd(iec_pkg::IRQ_ADDR); check(rd_val, 32'h0);
    i_iec_pins.drive(5'h05);
    repeat (2) @(posedge clk);
    rd(iec_pkg::IRQ_ADDR); check(rd_val, 32'h0000_0005);
    wr(iec_pkg::IRQ_ADDR, 32'h0000_0001);
    rd(iec_pkg::IRQ_ADDR); check(rd_val, 32'h0000_0004);
    i_iec_pins.drive(5'h00);
  endtask

  // Reset in mid-run must bring every implemented bit back to zero
  task automatic scen_reset;
    wr(iec_pkg::CTRL_ADDR, 32'h0000_801F);
    @(posedge clk) reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(iec_pkg::CTRL_ADDR); check(rd_val, 32'h0);
    check({31'h0, alt}, 32'h0);
    rd(iec_pkg::IRQ_ADDR); check(rd_val, 32'h0);
  endtask

  // Reset for four cycles, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    scen_reg();
    scen_disable();
    scen_pending();
    scen_reset();
    edge_test(5'h00, 5'h00, 5'h1F, 5'h1F);
    edge_test(5'h00, 5'h1F, 5'h00, 5'h00);
    edge_test(5'h1F, 5'h1F, 5'h00, 5'h1F);
    edge_test(5'h1F, 5'h00, 5'h1F, 5'h00);
    edge_test(5'h0A, 5'h00, 5'h1F, 5'h15);
    edge_test(5'h0A, 5'h1F, 5'h00, 5'h0A);
    summarize();
  end
endmodule
